// File: unpacker_consts.vh
`ifndef UNPACKER_CONSTS_VH
`define UNPACKER_CONSTS_VH

// unpacking mode codes on the MODE input
`define MODE_RGB3 3'h0
`define MODE_MONO8 3'h1
`define MODE_MONO7 3'h2
`define MODE_MONO6 3'h3
`define MODE_MONO5 3'h4
`define MODE_MONO4 3'h5
`define MODE_MONO3 3'h6
`define MODE_MONO2 3'h7

// frame rate codes on the RATE input
`define RATE_60 2'h0
`define RATE_45 2'h1
`define RATE_30 2'h2
`define RATE_15 2'h3

// images packed per input frame, per mode
`define IMGS_RGB3 4'h8
`define IMGS_MONO8 4'h2
`define IMGS_MONO7 4'h3
`define IMGS_MONO6 4'h4
`define IMGS_MONO5 4'h4
`define IMGS_MONO4 4'h6
`define IMGS_MONO3 4'h8
`define IMGS_MONO2 4'hc

// slice geometry: first bit of image 0, for modes whose slices do not start at bit 0
`define BIT_OFS_MONO7 5'h01
`define BIT_OFS_MONO5 5'h01
`define BIT_OFS_MONO8 5'h08

// sequence numbers
`define SEQ_RGB3 8'h0d
`define SEQ_MONO87 8'h10
`define SEQ_MONO65 8'h0f
`define SEQ_MONO432 8'h0e

// start vector families (60, 45/40, 30, 15 Hz)
`define SV_A60 8'h00
`define SV_A45 8'h0c
`define SV_A30 8'h0d
`define SV_A15 8'h0e
`define SV_B60 8'h0f
`define SV_B45 8'h1b
`define SV_B30 8'h1c
`define SV_B15 8'h1d
`define SV_C60 8'h1e
`define SV_C45 8'h2a
`define SV_C30 8'h2b
`define SV_C15 8'h2c
`define SV_D60 8'h2d
`define SV_D45 8'h39
`define SV_D30 8'h3a
`define SV_D15 8'h3b

// every unpacking sequence uses the same sub-vector
`define SUB_VECTOR_VAL 8'h01
`define SUB_VECTOR_SHIFT 8

// documented input frame size
`define FRAME_PIXELS_DEF 415872
`define FRAME_AW_DEF 19

`endif

// File: frame_store.v
`timescale 1ns/10ps
// two-bank pixel store, one write port and one registered read port
module frame_store
#(
    parameter WIDTH = 24,
    parameter AW = 19
)
(
    input wire clk,
    input wire wr_en,
    input wire [AW:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire rd_en,
    input wire [AW:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:(2<<AW)-1];

    // array carries no reset; contents are only read after a full frame is written
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// File: image_slicer.v
`timescale 1ns/10ps
`include "unpacker_consts.vh"
// picks one image out of a packed 24-bit word {green, red, blue}
module image_slicer
(
    input wire [23:0] word,
    input wire [2:0] mode,
    input wire [3:0] image,
    output reg [7:0] pix
);
    reg [4:0] width;
    reg [4:0] stride;
    reg [4:0] offset;
    reg [4:0] shift;
    reg [23:0] shifted;
    reg [7:0] mask;

    // per-mode geometry; the unused pins fall below the first slice (offset) or between slices
    always @*
    begin
        width = 5'h00;
        stride = 5'h00;
        offset = 5'h00;
        case (mode)
            `MODE_MONO8:
            begin
                width = 5'h08; stride = 5'h08; offset = `BIT_OFS_MONO8;
            end
            `MODE_MONO7:
            begin
                width = 5'h07; stride = 5'h08; offset = `BIT_OFS_MONO7;
            end
            `MODE_MONO6:
            begin
                width = 5'h06; stride = 5'h06;
            end
            `MODE_MONO5:
            begin
                width = 5'h05; stride = 5'h06; offset = `BIT_OFS_MONO5;
            end
            `MODE_MONO4:
            begin
                width = 5'h04; stride = 5'h04;
            end
            `MODE_MONO3:
            begin
                width = 5'h03; stride = 5'h03;
            end
            `MODE_MONO2:
            begin
                width = 5'h02; stride = 5'h02;
            end
            default:
            begin
                width = 5'h01; stride = 5'h01;
            end
        endcase
        // 7-bit mode starts at blue and moves to red then green
        if (mode == `MODE_MONO7)
        begin
            case (image)
                4'h0: shift = 5'h01;
                4'h1: shift = 5'h09;
                default: shift = 5'h11;
            endcase
        end
        else
        begin
            shift = stride * image[2:0] + (image[3] ? stride * 5'h08 : 5'h00) + offset;
        end
        shifted = word >> shift;
        mask = 8'hff >> (5'h08 - width);
        if (mode == `MODE_RGB3)
        begin
            // bit k of each colour becomes a one-bit r,g,b image
            pix = {5'h00, word[5'h08 + image[2:0]], word[5'h10 + image[2:0]],
                word[image[2:0]]};
        end
        else if (mode == `MODE_MONO8)
        begin
            pix = image[0] ? word[23:16] : word[15:8];
        end
        else
        begin
            pix = shifted[7:0] & mask;
        end
    end
endmodule

// File: bitplane_unpacker.v
`timescale 1ns/10ps
`include "unpacker_consts.vh"
module bitplane_unpacker
#(
    parameter FRAME_PIXELS = `FRAME_PIXELS_DEF,
    parameter AW = `FRAME_AW_DEF
)
(
    input wire CLOCK,
    input wire RESETN,
    input wire [2:0] MODE,
    input wire [1:0] RATE,
    input wire VSYNC,
    input wire PIXEL_VALID,
    input wire [7:0] RED,
    input wire [7:0] GREEN,
    input wire [7:0] BLUE,
    input wire TRIG_IN_EN,
    input wire TRIG_IN,
    output reg DISP_VALID,
    output reg [3:0] DISP_IMAGE,
    output reg [7:0] DISP_PIXEL,
    output reg TRIG_OUT,
    output wire DISP_BUSY,
    output reg [2:0] ACTIVE_MODE,
    output reg [3:0] IMAGES_PER_FRAME,
    output reg [7:0] SEQ_NUMBER,
    output reg [7:0] START_VECTOR,
    output wire [7:0] SUB_VECTOR,
    output wire [15:0] SEQ_VECTOR
);
    localparam S_IDLE = 2'h0;
    localparam S_ARM = 2'h1;
    localparam S_RUN = 2'h2;
    localparam [AW:0] FRAME_LIMIT = FRAME_PIXELS;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg vsync_d_r;
    reg bank_r;
    reg [AW:0] wr_cnt_r;
    reg [AW:0] disp_len_r;
    reg [AW:0] rd_addr_r;
    reg [AW:0] rd_addr_nxt;
    reg [3:0] image_r;
    reg [3:0] image_nxt;
    reg [2:0] cap_mode_r;
    reg [2:0] disp_mode_r;
    reg [3:0] disp_count;
    reg rd_fire;
    reg first_r;
    reg first_nxt;
    reg v1_r;
    reg first1_r;
    reg [3:0] img1_r;
    wire vs_rise;
    wire wr_fire;
    wire [AW:0] wr_addr;
    wire [AW:0] rd_addr;
    wire [23:0] rd_word;
    wire [7:0] slice;

    assign vs_rise = VSYNC & ~vsync_d_r;
    // pixels beyond the frame size (FRAME_PIXELS) are dropped rather than wrapped
    assign wr_fire = PIXEL_VALID & ~vs_rise & (wr_cnt_r < FRAME_LIMIT);
    assign wr_addr = {bank_r, wr_cnt_r[AW-1:0]};
    assign rd_addr = {~bank_r, rd_addr_r[AW-1:0]};
    assign DISP_BUSY = (state_r != S_IDLE) | v1_r;

    // the sub-vector is fixed for all unpacking variants
    assign SUB_VECTOR = `SUB_VECTOR_VAL;
    assign SEQ_VECTOR = {SUB_VECTOR, START_VECTOR};

    // images per frame of the mode being displayed
    always @*
    begin
        case (disp_mode_r)
            `MODE_RGB3: disp_count = `IMGS_RGB3;
            `MODE_MONO8: disp_count = `IMGS_MONO8;
            `MODE_MONO7: disp_count = `IMGS_MONO7;
            `MODE_MONO6: disp_count = `IMGS_MONO6;
            `MODE_MONO5: disp_count = `IMGS_MONO5;
            `MODE_MONO4: disp_count = `IMGS_MONO4;
            `MODE_MONO3: disp_count = `IMGS_MONO3;
            `MODE_MONO2: disp_count = `IMGS_MONO2;
            default: disp_count = `IMGS_RGB3;
        endcase
    end

    // capture side: write pixels of the current frame into the write bank
    always @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            vsync_d_r <= 1'b0;
            bank_r <= 1'b0;
            wr_cnt_r <= {(AW+1){1'b0}};
            disp_len_r <= {(AW+1){1'b0}};
            cap_mode_r <= `MODE_RGB3;
            disp_mode_r <= `MODE_RGB3;
        end
        else
        begin
            vsync_d_r <= VSYNC;
            if (vs_rise)
            begin
                // swap banks; last frame becomes the one shown now
                bank_r <= ~bank_r;
                disp_len_r <= wr_cnt_r;
                wr_cnt_r <= {(AW+1){1'b0}};
                // mapping follows the frame it was captured with
                disp_mode_r <= cap_mode_r;
                cap_mode_r <= MODE;
            end
            else if (wr_fire)
            begin
                wr_cnt_r <= wr_cnt_r + {{AW{1'b0}}, 1'b1};
            end
        end
    end

    // display sequencer: one pass over the stored frame per image
    always @*
    begin
        state_nxt = state_r;
        rd_addr_nxt = rd_addr_r;
        image_nxt = image_r;
        first_nxt = 1'b0;
        rd_fire = 1'b0;
        case (state_r)
            S_IDLE:
            begin
                state_nxt = S_IDLE;
            end
            S_ARM:
            begin
                // external trigger gates the start of each image
                if (!TRIG_IN_EN || TRIG_IN)
                begin
                    state_nxt = S_RUN;
                    rd_addr_nxt = {(AW+1){1'b0}};
                    first_nxt = 1'b1;
                end
            end
            S_RUN:
            begin
                rd_fire = 1'b1;
                if (rd_addr_r == disp_len_r - {{AW{1'b0}}, 1'b1})
                begin
                    // the whole set of images ends one frame behind the load
                    if (image_r == disp_count - 4'h1)
                    begin
                        state_nxt = S_IDLE;
                    end
                    else
                    begin
                        image_nxt = image_r + 4'h1;
                        state_nxt = S_ARM;
                    end
                end
                else
                begin
                    rd_addr_nxt = rd_addr_r + {{AW{1'b0}}, 1'b1};
                end
            end
            default:
            begin
                state_nxt = S_IDLE;
            end
        endcase
        // a new frame restarts display if the stored frame holds pixels, else goes idle, abandoning any unfinished pass
        if (vs_rise)
        begin
            image_nxt = 4'h0;
            rd_addr_nxt = {(AW+1){1'b0}};
            first_nxt = 1'b0;
            state_nxt = (wr_cnt_r != {(AW+1){1'b0}}) ? S_ARM : S_IDLE;
        end
    end

    always @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            state_r <= S_IDLE;
            rd_addr_r <= {(AW+1){1'b0}};
            image_r <= 4'h0;
            first_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            rd_addr_r <= rd_addr_nxt;
            image_r <= image_nxt;
            first_r <= first_nxt;
        end
    end

    frame_store #(
        .WIDTH(24),
        .AW(AW)
    ) u_store (
        .clk(CLOCK),
        .wr_en(wr_fire),
        .wr_addr(wr_addr),
        .wr_data({GREEN, RED, BLUE}),
        .rd_en(rd_fire),
        .rd_addr(rd_addr),
        .rd_data(rd_word)
    );

    image_slicer u_slicer (
        .word(rd_word),
        .mode(disp_mode_r),
        .image(img1_r),
        .pix(slice)
    );

    // two-stage output pipe: store read, then slice into flops
    always @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            v1_r <= 1'b0;
            first1_r <= 1'b0;
            img1_r <= 4'h0;
            DISP_VALID <= 1'b0;
            DISP_IMAGE <= 4'h0;
            DISP_PIXEL <= 8'h00;
            TRIG_OUT <= 1'b0;
        end
        else
        begin
            v1_r <= rd_fire;
            first1_r <= rd_fire & first_r;
            img1_r <= image_r;
            DISP_VALID <= v1_r;
            DISP_IMAGE <= img1_r;
            DISP_PIXEL <= v1_r ? slice : 8'h00;
            // output trigger marks the first pixel of every image
            TRIG_OUT <= first1_r;
        end
    end

    // sequence selection for the mode requested now, mode and image count for the one displayed; the host loads it
    always @(posedge CLOCK)
    begin
        if (!RESETN)
        begin
            ACTIVE_MODE <= `MODE_RGB3;
            IMAGES_PER_FRAME <= `IMGS_RGB3;
            SEQ_NUMBER <= `SEQ_RGB3;
            START_VECTOR <= `SV_A60;
        end
        else
        begin
            ACTIVE_MODE <= disp_mode_r;
            IMAGES_PER_FRAME <= disp_count;
            case (MODE)
                `MODE_MONO8, `MODE_MONO7: SEQ_NUMBER <= `SEQ_MONO87;
                `MODE_MONO6, `MODE_MONO5: SEQ_NUMBER <= `SEQ_MONO65;
                `MODE_MONO4, `MODE_MONO3, `MODE_MONO2: SEQ_NUMBER <= `SEQ_MONO432;
                default: SEQ_NUMBER <= `SEQ_RGB3;
            endcase
            // four rate variants per mode, grouped into vector families
            case (MODE)
                `MODE_MONO8, `MODE_MONO6, `MODE_MONO2:
                begin
                    case (RATE)
                        `RATE_60: START_VECTOR <= `SV_B60;
                        `RATE_45: START_VECTOR <= `SV_B45;
                        `RATE_30: START_VECTOR <= `SV_B30;
                        default: START_VECTOR <= `SV_B15;
                    endcase
                end
                `MODE_MONO4:
                begin
                    case (RATE)
                        `RATE_60: START_VECTOR <= `SV_D60;
                        `RATE_45: START_VECTOR <= `SV_D45;
                        `RATE_30: START_VECTOR <= `SV_D30;
                        default: START_VECTOR <= `SV_D15;
                    endcase
                end
                `MODE_MONO3:
                begin
                    case (RATE)
                        `RATE_60: START_VECTOR <= `SV_C60;
                        `RATE_45: START_VECTOR <= `SV_C45;
                        `RATE_30: START_VECTOR <= `SV_C30;
                        default: START_VECTOR <= `SV_C15;
                    endcase
                end
                default:
                begin
                    case (RATE)
                        `RATE_60: START_VECTOR <= `SV_A60;
                        `RATE_45: START_VECTOR <= `SV_A45;
                        `RATE_30: START_VECTOR <= `SV_A30;
                        default: START_VECTOR <= `SV_A15;
                    endcase
                end
            endcase
        end
    end
endmodule

// File: video_source.sv
`timescale 1ns/10ps
module video_source
(
    input wire CLOCK,
    output reg VSYNC,
    output reg PIXEL_VALID,
    output reg [7:0] RED,
    output reg [7:0] GREEN,
    output reg [7:0] BLUE
);
    logic [23:0] words[$];

    // bus starts idle
    initial
    begin
        VSYNC = 1'b0;
        PIXEL_VALID = 1'b0;
        {GREEN, RED, BLUE} = 24'h00_0000;
    end

    // one sync pulse, then n pixels, spaced at random when gaps is set
    task automatic send_frame(input int n, input bit gaps);
        int i;
        bit v;
        logic [23:0] w;
        words.delete();
        @(posedge CLOCK);
        VSYNC <= 1'b1;
        i = 0;
        w = 24'h00_0000;
        while (i < n)
        begin
            @(posedge CLOCK);
            VSYNC <= 1'b0;
            w = 24'($urandom);
            v = !gaps || ($urandom_range(1) == 1);
            PIXEL_VALID <= v;
            // idle cycles carry junk so a stale word cannot pass for a pixel
            {GREEN, RED, BLUE} <= w;
            if (v)
            begin
                words.push_back(w);
                i++;
            end
        end
        @(posedge CLOCK);
        VSYNC <= 1'b0;
        PIXEL_VALID <= 1'b0;
        {GREEN, RED, BLUE} <= ~w;
    endtask
endmodule

// File: unpacker_asserts.sv
`timescale 1ns/10ps
module unpacker_asserts
(
    input wire CLOCK,
    input wire RESETN,
    input wire [2:0] MODE,
    input wire [1:0] RATE,
    input wire VSYNC,
    input wire DISP_VALID,
    input wire [3:0] DISP_IMAGE,
    input wire [7:0] DISP_PIXEL,
    input wire TRIG_OUT,
    input wire [2:0] ACTIVE_MODE,
    input wire [3:0] IMAGES_PER_FRAME,
    input wire [7:0] SEQ_NUMBER,
    input wire [7:0] START_VECTOR,
    input wire [7:0] SUB_VECTOR,
    input wire [15:0] SEQ_VECTOR
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    function automatic logic [7:0] seq_of(input logic [2:0] m);
        return (m == 3'h0) ? 8'h0d : (m < 3'h3) ? 8'h10 : (m < 3'h5) ? 8'h0f : 8'h0e;
    endfunction

    function automatic logic [7:0] sv_of(input logic [2:0] m, input logic [1:0] r);
        logic [7:0] base[8] = '{8'h00, 8'h0f, 8'h00, 8'h0f, 8'h00, 8'h2d, 8'h1e, 8'h0f};
        return base[m] + ((r == 2'h0) ? 8'h00 : 8'h0b + r);
    endfunction

    function automatic logic [3:0] cnt_of(input logic [2:0] m);
        logic [3:0] c[8] = '{4'h8, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h8, 4'hc};
        return c[m];
    endfunction

    property p_seq_vec; SEQ_VECTOR == {SUB_VECTOR, START_VECTOR}; endproperty
    a_seq_vec: assert property (p_seq_vec) else $error("sequence vector not sub and start");
    property p_sub_one; SUB_VECTOR == 8'h01; endproperty
    a_sub_one: assert property (p_sub_one) else $error("sub vector not one");
    property p_seq_num; 1'b1 |=> SEQ_NUMBER == seq_of($past(MODE)); endproperty
    a_seq_num: assert property (p_seq_num) else $error("sequence number wrong");
    property p_start_vec; 1'b1 |=> START_VECTOR == sv_of($past(MODE), $past(RATE)); endproperty
    a_start_vec: assert property (p_start_vec) else $error("start vector wrong");
    property p_trig_rise; $rose(DISP_VALID) |-> TRIG_OUT; endproperty
    a_trig_rise: assert property (p_trig_rise) else $error("image began without trigger");
    property p_trig_only; TRIG_OUT |-> DISP_VALID && !$past(DISP_VALID); endproperty
    a_trig_only: assert property (p_trig_only) else $error("trigger off image start");
    property p_pix_zero; !DISP_VALID |-> DISP_PIXEL == 8'h00; endproperty
    a_pix_zero: assert property (p_pix_zero) else $error("pixel not zero when idle");
    property p_img_range; DISP_VALID |-> DISP_IMAGE < IMAGES_PER_FRAME; endproperty
    a_img_range: assert property (p_img_range) else $error("image index out of range");
    property p_ipf; IMAGES_PER_FRAME == cnt_of(ACTIVE_MODE); endproperty
    a_ipf: assert property (p_ipf) else $error("image count wrong for mode");
    property p_mode_sync;
        $changed(ACTIVE_MODE) |-> $past(VSYNC, 1) || $past(VSYNC, 2) || $past(VSYNC, 3);
    endproperty
    a_mode_sync: assert property (p_mode_sync) else $error("mode changed away from sync");
endmodule

bind bitplane_unpacker unpacker_asserts i_chk (.CLOCK(CLOCK), .RESETN(RESETN), .MODE(MODE),
    .RATE(RATE), .VSYNC(VSYNC), .DISP_VALID(DISP_VALID), .DISP_IMAGE(DISP_IMAGE),
    .DISP_PIXEL(DISP_PIXEL), .TRIG_OUT(TRIG_OUT), .ACTIVE_MODE(ACTIVE_MODE),
    .IMAGES_PER_FRAME(IMAGES_PER_FRAME), .SEQ_NUMBER(SEQ_NUMBER),
    .START_VECTOR(START_VECTOR), .SUB_VECTOR(SUB_VECTOR), .SEQ_VECTOR(SEQ_VECTOR));

// File: tb.sv
`timescale 1ns/10ps
module tb;
    logic CLOCK, RESETN, TRIG_IN_EN, TRIG_IN, VSYNC, PIXEL_VALID;
    logic [2:0] MODE;
    logic [1:0] RATE;
    logic [7:0] RED, GREEN, BLUE;
    wire DISP_VALID, TRIG_OUT, DISP_BUSY;
    wire [3:0] DISP_IMAGE, IMAGES_PER_FRAME;
    wire [7:0] DISP_PIXEL, SEQ_NUMBER, START_VECTOR, SUB_VECTOR;
    wire [2:0] ACTIVE_MODE;
    wire [15:0] SEQ_VECTOR;
    int n_errors = 0, num_checks = 0, n_trig = 0, cyc = 0, pm = 0;
    int imgs[8] = '{8, 2, 3, 4, 4, 6, 8, 12};
    logic [11:0] exp_q[$];
    logic [23:0] prev[$];

    bitplane_unpacker #(.FRAME_PIXELS(8), .AW(3)) i_bitplane_unpacker (.CLOCK(CLOCK),
        .RESETN(RESETN), .MODE(MODE), .RATE(RATE), .VSYNC(VSYNC), .PIXEL_VALID(PIXEL_VALID),
        .RED(RED), .GREEN(GREEN), .BLUE(BLUE), .TRIG_IN_EN(TRIG_IN_EN), .TRIG_IN(TRIG_IN),
        .DISP_VALID(DISP_VALID), .DISP_IMAGE(DISP_IMAGE), .DISP_PIXEL(DISP_PIXEL),
        .TRIG_OUT(TRIG_OUT), .DISP_BUSY(DISP_BUSY), .ACTIVE_MODE(ACTIVE_MODE),
        .IMAGES_PER_FRAME(IMAGES_PER_FRAME), .SEQ_NUMBER(SEQ_NUMBER),
        .START_VECTOR(START_VECTOR), .SUB_VECTOR(SUB_VECTOR), .SEQ_VECTOR(SEQ_VECTOR));
    video_source i_video_source (.CLOCK(CLOCK), .VSYNC(VSYNC), .PIXEL_VALID(PIXEL_VALID),
        .RED(RED), .GREEN(GREEN), .BLUE(BLUE));

    // 10 MHz clock
    initial
    begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // reference slice of image k from word {green, red, blue}
    function automatic logic [7:0] slice(input int m, input int k, input logic [23:0] w);
        int wid[8] = '{1, 8, 7, 6, 5, 4, 3, 2};
        int str[8] = '{1, 8, 8, 6, 6, 4, 3, 2};
        int ofs[8] = '{0, 8, 1, 0, 1, 0, 0, 0};
        if (m == 0)
            return {5'h00, w[8 + k], w[16 + k], w[k]};
        return 8'((w >> (str[m] * k + ofs[m])) & ((1 << wid[m]) - 1));
    endfunction

    // scoreboard on every displayed pixel; trigger input toggles at random
    always @(posedge CLOCK)
    begin
        TRIG_IN <= 1'($urandom_range(1));
        if (RESETN === 1'b1 && DISP_VALID === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("extra_pixel", 16'h0001, 16'h0000);
            else
            begin
                chk("image", 16'(DISP_IMAGE), 16'(exp_q[0][11:8]));
                chk("pixel", 16'(DISP_PIXEL), 16'(exp_q[0][7:0]));
                void'(exp_q.pop_front());
            end
        end
        if (TRIG_OUT === 1'b1)
            n_trig++;
    end

    // hang guard, well above the planned run
    always @(posedge CLOCK)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_errors++;
            $display("[FAIL] timeout expected done seen hung");
            summarize();
        end
    end

    // one input frame; the sync that opens it shows the previous one
    task automatic run_frame(input int f, input int m, input int n, input bit trig);
        int k;
        int ntrig_exp;
        MODE <= m[2:0];
        RATE <= 2'($urandom_range(3));
        TRIG_IN_EN <= trig;
        n_trig = 0;
        ntrig_exp = 0;
        for (k = 0; prev.size() > 0 && k < imgs[pm]; k++)
        begin
            ntrig_exp++;
            foreach (prev[p])
                exp_q.push_back({4'(k), slice(pm, k, prev[p])});
        end
        i_video_source.send_frame(n, f % 3 == 1);
        prev = i_video_source.words;
        // pixels past the frame size are dropped
        while (prev.size() > 8)
            void'(prev.pop_back());
        pm = m;
        // junk mode mid-frame must not reach the frame already latched
        MODE <= 3'($urandom);
        repeat (140) @(posedge CLOCK);
        chk("images_left", 16'(exp_q.size()), 16'h0000);
        chk("trig_count", 16'(n_trig), 16'(ntrig_exp));
        $display("frame %0d mode %0d done", f, m);
    endtask

    // main sequence
    initial
    begin
        int seqn[8] = '{13, 16, 16, 15, 15, 14, 14, 14};
        int base[8] = '{0, 15, 0, 15, 0, 45, 30, 15};
        RESETN = 1'b0;
        MODE = 3'h0;
        RATE = 2'h0;
        TRIG_IN_EN = 1'b0;
        TRIG_IN = 1'b0;
        void'($urandom(32'h074e));
        repeat (3) @(posedge CLOCK);
        RESETN <= 1'b1;
        @(posedge CLOCK);
        #1;
        chk("reset_seq_vector", SEQ_VECTOR, 16'h0100);
        chk("reset_images", 16'(IMAGES_PER_FRAME), 16'h0008);
        // every mode against every frame rate
        for (int m = 0; m < 8; m++)
            for (int r = 0; r < 4; r++)
            begin
                @(posedge CLOCK);
                MODE <= m[2:0];
                RATE <= r[1:0];
                @(posedge CLOCK);
                #1;
                chk("seq_number", 16'(SEQ_NUMBER), 16'(seqn[m]));
                chk("seq_vector", SEQ_VECTOR, 16'h0100 + base[m] + (r == 0 ? 0 : 11 + r));
            end
        $display("sequence table done");
        @(posedge CLOCK);
        for (int f = 0; f < 13; f++)
            run_frame(f, f < 8 ? f : $urandom_range(7), f == 12 ? 0 : (f == 5 ? 10 : 4), f == 9);
        summarize();
    end
endmodule
